// ==== include/cvd_ctrl_map.vh ====
`ifndef CVD_CTRL_MAP_VH
`define CVD_CTRL_MAP_VH
`define OFS_CONV0_A 8'h00
`define OFS_CONV0_B 8'h04
`define OFS_CONV1 8'h08
`define OFS_CVD3_A 8'h0C
`define OFS_CVD3_B 8'h10
`define OFS_START 8'h14
`define OFS_STATUS 8'h18
`define OFS_MASK 8'h1C
`define OFS_STATE 8'h20
`define CHS_W 6
`define CVD3_EPPOL 7
`define CVD3_IPPOL 6
`define CVD3_IPEN 1
`define CVD3_DSEN 0
`define CVD3_MASK 8'h C3
`define CVD3_RESET 8'h00
`define CONV1_RESET 8'h00
`define TAD_HALVES 5'h17
`define CLKSEL_FRC 3'h7
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ==== verilog/cvd_sequence_control.v ====
// What this block does
// - route each converter's channel field to hold
// - channels 0 to 2 shared by both
// - positive reference pin or supply, negative ground
// - seven conversion clocks: dividers or internal rc
// - conversion lasts eleven and half periods
// - divided clocks track system clock, rc independent
// - external precharge polarity: supply or ground
// - internal precharge: hold to positive/negative reference
// - invert polarities on second sample only
// - invert ignored without double sample
// - double sample starts second conversion immediately
//
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "cvd_ctrl_map.vh"
module cvd_sequence_control
(
   input wire CLOCK_IN,
   input wire RSTN_IN,
   input wire FRC_CLK_IN,
   input wire [31:0] S_AXI_AWADDR_IN,
   input wire S_AXI_AWVALID_IN,
   output reg S_AXI_AWREADY_OUT,
   input wire [31:0] S_AXI_WDATA_IN,
   input wire [3:0] S_AXI_WSTRB_IN,
   input wire S_AXI_WVALID_IN,
   output reg S_AXI_WREADY_OUT,
   output reg [1:0] S_AXI_BRESP_OUT,
   output reg S_AXI_BVALID_OUT,
   input wire S_AXI_BREADY_IN,
   input wire [31:0] S_AXI_ARADDR_IN,
   input wire S_AXI_ARVALID_IN,
   output reg S_AXI_ARREADY_OUT,
   output reg [31:0] S_AXI_RDATA_OUT,
   output reg [1:0] S_AXI_RRESP_OUT,
   output reg S_AXI_RVALID_OUT,
   input wire S_AXI_RREADY_IN,
   output reg [5:0] HOLD_A_CHANNEL_OUT,
   output reg [5:0] HOLD_B_CHANNEL_OUT,
   output reg POS_REF_SUPPLY_OUT,
   output reg NEG_REF_GROUND_OUT,
   output reg CONV_CLK_OUT,
   output reg [1:0] BUSY_OUT,
   output reg [1:0] PRECHARGE_OUT,
   output reg [1:0] EXT_PRECHARGE_SUPPLY_OUT,
   output reg [1:0] INT_PRECHARGE_POS_OUT,
   output reg [1:0] GUARD_INVERT_OUT,
   output reg [1:0] SECOND_SAMPLE_OUT,
   output reg IRQ_OUT
);
   reg [7:0] conv0_a;
   reg [7:0] conv0_b;
   reg [7:0] conv1;
   reg [7:0] cvd3_a;
   reg [7:0] cvd3_b;
   reg [3:0] irq_status;
   reg [3:0] irq_mask;
   reg [31:0] awaddr;
   reg [31:0] wdata;
   reg [3:0] wstrb;
   reg aw_held;
   reg w_held;
   reg frc_s1;
   reg frc_s2;
   reg frc_s3;
   reg [5:0] div_cnt;
   reg tick;
   reg [1:0] running;
   reg [1:0] second;
   reg [4:0] half_cnt_a;
   reg [4:0] half_cnt_b;
   reg [1:0] start_req;
   reg [1:0] done;
   reg [3:0] next_set;
   integer k;

   // shared channels 0..2 are legal for both; upper codes are per converter
   function [5:0] route_channel;
      input [7:0] ctrl;
      begin
         route_channel = ctrl[7:2];
      end
   endfunction

   function [0:0] tap_of;
      input [2:0] sel;
      input [5:0] cnt;
      input frc_edge;
      begin
         case (sel)
            3'h0: tap_of = 1'b1;
            3'h1: tap_of = (cnt[0] == 1'b1);
            3'h2: tap_of = (cnt[1:0] == 2'h3);
            3'h3: tap_of = (cnt[2:0] == 3'h7);
            3'h4: tap_of = (cnt[3:0] == 4'hF);
            3'h5: tap_of = (cnt[4:0] == 5'h1F);
            3'h6: tap_of = (cnt[4:0] == 5'h1F);
            default: tap_of = frc_edge;
         endcase
      end
   endfunction

   wire aw_ok = aw_held || S_AXI_AWVALID_IN;
   wire w_ok = w_held || S_AXI_WVALID_IN;
   wire [31:0] wr_addr = aw_held ? awaddr : S_AXI_AWADDR_IN;
   wire [31:0] wr_data = w_held ? wdata : S_AXI_WDATA_IN;
   wire [3:0] wr_strb = w_held ? wstrb : S_AXI_WSTRB_IN;
   wire do_write = aw_ok && w_ok && (aw_held || S_AXI_AWREADY_OUT)
      && (w_held || S_AXI_WREADY_OUT) && !S_AXI_BVALID_OUT;
   wire wr_hit = (wr_addr[31:6] == 26'h000_0000) && (wr_addr[1:0] == 2'b00)
      && (wr_addr[5:0] <= `OFS_STATE);
   wire frc_edge = frc_s2 && !frc_s3;
   // a half-tick: system divider taps track Fosc, rc tick ignores it
   wire half_tick = tap_of(conv1[6:4], div_cnt, frc_edge);
   wire fresh_start = (start_req != 2'b00) && (running == 2'b00);

   always @(posedge CLOCK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         frc_s1 <= 1'b0;
         frc_s2 <= 1'b0;
         frc_s3 <= 1'b0;
         div_cnt <= 6'h00;
         tick <= 1'b0;
      end
      else
      begin
         frc_s1 <= FRC_CLK_IN;
         frc_s2 <= frc_s1;
         frc_s3 <= frc_s2;
         // restart the divider so the first period of a sequence is whole
         div_cnt <= fresh_start ? 6'h01 : div_cnt + 6'h01;
         tick <= fresh_start ? tap_of(conv1[6:4], 6'h00, 1'b0) : half_tick;
      end
   end

   // write channel and register file
   always @(posedge CLOCK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         awaddr <= 32'h0000_0000;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
         S_AXI_AWREADY_OUT <= 1'b0;
         S_AXI_WREADY_OUT <= 1'b0;
         S_AXI_BVALID_OUT <= 1'b0;
         S_AXI_BRESP_OUT <= `RESP_OKAY;
         conv0_a <= 8'h00;
         conv0_b <= 8'h00;
         conv1 <= `CONV1_RESET;
         cvd3_a <= `CVD3_RESET;
         cvd3_b <= `CVD3_RESET;
         irq_mask <= 4'h0;
         start_req <= 2'b00;
      end
      else
      begin
         S_AXI_AWREADY_OUT <= !aw_held && !S_AXI_AWREADY_OUT && !do_write;
         S_AXI_WREADY_OUT <= !w_held && !S_AXI_WREADY_OUT && !do_write;
         start_req <= 2'b00;
         if (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && !do_write)
         begin
            aw_held <= 1'b1;
            awaddr <= S_AXI_AWADDR_IN;
         end
         if (S_AXI_WVALID_IN && S_AXI_WREADY_OUT && !do_write)
         begin
            w_held <= 1'b1;
            wdata <= S_AXI_WDATA_IN;
            wstrb <= S_AXI_WSTRB_IN;
         end
         if (S_AXI_BVALID_OUT && S_AXI_BREADY_IN)
            S_AXI_BVALID_OUT <= 1'b0;
         if (do_write && (aw_held || S_AXI_AWREADY_OUT) && (w_held || S_AXI_WREADY_OUT))
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_AWREADY_OUT <= 1'b0;
            S_AXI_WREADY_OUT <= 1'b0;
            S_AXI_BVALID_OUT <= 1'b1;
            S_AXI_BRESP_OUT <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            if (wr_hit && wr_strb[0])
            begin
               case (wr_addr[7:0])
                  `OFS_CONV0_A: conv0_a <= wr_data[7:0];
                  `OFS_CONV0_B: conv0_b <= wr_data[7:0];
                  `OFS_CONV1: conv1 <= wr_data[7:0];
                  `OFS_CVD3_A: cvd3_a <= wr_data[7:0] & `CVD3_MASK;
                  `OFS_CVD3_B: cvd3_b <= wr_data[7:0] & `CVD3_MASK;
                  `OFS_START: start_req <= wr_data[1:0] & ~running;
                  `OFS_MASK: irq_mask <= wr_data[3:0];
                  default: ;
               endcase
            end
         end
      end
   end

   // conversion sequencer per converter; 23 half-periods is 11.5 periods
   always @(posedge CLOCK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         running <= 2'b00;
         second <= 2'b00;
         half_cnt_a <= 5'h00;
         half_cnt_b <= 5'h00;
         done <= 2'b00;
      end
      else
      begin
         done <= 2'b00;
         for (k = 0; k < 2; k = k + 1)
         begin
            if (start_req[k])
            begin
               running[k] <= 1'b1;
               second[k] <= 1'b0;
            end
         end
         if (running[0] && tick)
         begin
            if (half_cnt_a == `TAD_HALVES - 5'h01)
            begin
               half_cnt_a <= 5'h00;
               if (cvd3_a[`CVD3_DSEN] && !second[0])
                  second[0] <= 1'b1;
               else
               begin
                  running[0] <= 1'b0;
                  second[0] <= 1'b0;
                  done[0] <= 1'b1;
               end
            end
            else
               half_cnt_a <= half_cnt_a + 5'h01;
         end
         if (running[1] && tick)
         begin
            if (half_cnt_b == `TAD_HALVES - 5'h01)
            begin
               half_cnt_b <= 5'h00;
               if (cvd3_b[`CVD3_DSEN] && !second[1])
                  second[1] <= 1'b1;
               else
               begin
                  running[1] <= 1'b0;
                  second[1] <= 1'b0;
                  done[1] <= 1'b1;
               end
            end
            else
               half_cnt_b <= half_cnt_b + 5'h01;
         end
      end
   end

   // status: set beats write-one-to-clear
   always @*
   begin
      next_set = {2'b00, done};
      next_set[3:2] = done & {cvd3_b[`CVD3_DSEN], cvd3_a[`CVD3_DSEN]};
   end

   always @(posedge CLOCK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
         irq_status <= 4'h0;
      else if (do_write && wr_hit && wr_strb[0] && wr_addr[7:0] == `OFS_STATUS
         && (aw_held || S_AXI_AWREADY_OUT) && (w_held || S_AXI_WREADY_OUT))
         irq_status <= (irq_status & ~wr_data[3:0]) | next_set;
      else
         irq_status <= irq_status | next_set;
   end

   // read channel, one cycle after address accepted
   always @(posedge CLOCK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         S_AXI_ARREADY_OUT <= 1'b0;
         S_AXI_RVALID_OUT <= 1'b0;
         S_AXI_RDATA_OUT <= 32'h0000_0000;
         S_AXI_RRESP_OUT <= `RESP_OKAY;
      end
      else
      begin
         S_AXI_ARREADY_OUT <= !S_AXI_ARREADY_OUT && !S_AXI_RVALID_OUT && S_AXI_ARVALID_IN;
         if (S_AXI_RVALID_OUT && S_AXI_RREADY_IN)
            S_AXI_RVALID_OUT <= 1'b0;
         if (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT)
         begin
            S_AXI_RVALID_OUT <= 1'b1;
            S_AXI_RRESP_OUT <= `RESP_OKAY;
            case (S_AXI_ARADDR_IN[7:0])
               `OFS_CONV0_A: S_AXI_RDATA_OUT <= {24'h00_0000, conv0_a};
               `OFS_CONV0_B: S_AXI_RDATA_OUT <= {24'h00_0000, conv0_b};
               `OFS_CONV1: S_AXI_RDATA_OUT <= {24'h00_0000, conv1};
               `OFS_CVD3_A: S_AXI_RDATA_OUT <= {24'h00_0000, cvd3_a};
               `OFS_CVD3_B: S_AXI_RDATA_OUT <= {24'h00_0000, cvd3_b};
               `OFS_START: S_AXI_RDATA_OUT <= {30'h0000_0000, running};
               `OFS_STATUS: S_AXI_RDATA_OUT <= {28'h000_0000, irq_status};
               `OFS_MASK: S_AXI_RDATA_OUT <= {28'h000_0000, irq_mask};
               `OFS_STATE: S_AXI_RDATA_OUT <= {28'h000_0000, second, running};
               default:
               begin
                  S_AXI_RDATA_OUT <= 32'h0000_0000;
                  S_AXI_RRESP_OUT <= `RESP_SLVERR;
               end
            endcase
            if (S_AXI_ARADDR_IN[31:8] != 24'h00_0000)
            begin
               S_AXI_RDATA_OUT <= 32'h0000_0000;
               S_AXI_RRESP_OUT <= `RESP_SLVERR;
            end
         end
      end
   end

   // analog-side controls, all registered
   always @(posedge CLOCK_IN or negedge RSTN_IN)
   begin
      if (!RSTN_IN)
      begin
         HOLD_A_CHANNEL_OUT <= 6'h00;
         HOLD_B_CHANNEL_OUT <= 6'h00;
         POS_REF_SUPPLY_OUT <= 1'b0;
         NEG_REF_GROUND_OUT <= 1'b1;
         CONV_CLK_OUT <= 1'b0;
         BUSY_OUT <= 2'b00;
         PRECHARGE_OUT <= 2'b00;
         EXT_PRECHARGE_SUPPLY_OUT <= 2'b00;
         INT_PRECHARGE_POS_OUT <= 2'b00;
         GUARD_INVERT_OUT <= 2'b00;
         SECOND_SAMPLE_OUT <= 2'b00;
         IRQ_OUT <= 1'b0;
      end
      else
      begin
         HOLD_A_CHANNEL_OUT <= route_channel(conv0_a);
         HOLD_B_CHANNEL_OUT <= route_channel(conv0_b);
         POS_REF_SUPPLY_OUT <= conv1[0];
         NEG_REF_GROUND_OUT <= 1'b1;
         if (tick && (running != 2'b00))
            CONV_CLK_OUT <= !CONV_CLK_OUT;
         else if (running == 2'b00)
            CONV_CLK_OUT <= 1'b0;
         BUSY_OUT <= running;
         // precharge during first two half-periods of each conversion
         PRECHARGE_OUT <= running & {half_cnt_b < 5'h02, half_cnt_a < 5'h02};
         // stored bits untouched; only applied value flips
         EXT_PRECHARGE_SUPPLY_OUT <= {cvd3_b[`CVD3_EPPOL] ^ (second[1] & cvd3_b[`CVD3_IPEN]),
            cvd3_a[`CVD3_EPPOL] ^ (second[0] & cvd3_a[`CVD3_IPEN])};
         INT_PRECHARGE_POS_OUT <= {cvd3_b[`CVD3_IPPOL] ^ (second[1] & cvd3_b[`CVD3_IPEN]),
            cvd3_a[`CVD3_IPPOL] ^ (second[0] & cvd3_a[`CVD3_IPEN])};
         GUARD_INVERT_OUT <= second & {cvd3_b[`CVD3_IPEN], cvd3_a[`CVD3_IPEN]};
         SECOND_SAMPLE_OUT <= second;
         IRQ_OUT <= |(irq_status & irq_mask);
      end
   end
endmodule

// ==== testbench/cvd_ctrl_checker_assertions.sv ====
`timescale 1ns/1ps
module cvd_ctrl_checker
(
   input wire CLOCK_IN,
   input wire RSTN_IN,
   input wire S_AXI_BVALID_OUT,
   input wire S_AXI_BREADY_IN,
   input wire S_AXI_ARVALID_IN,
   input wire S_AXI_ARREADY_OUT,
   input wire S_AXI_RVALID_OUT,
   input wire S_AXI_RREADY_IN,
   input wire [31:0] S_AXI_RDATA_OUT,
   input wire NEG_REF_GROUND_OUT,
   input wire CONV_CLK_OUT,
   input wire [1:0] BUSY_OUT,
   input wire [1:0] EXT_PRECHARGE_SUPPLY_OUT,
   input wire [1:0] GUARD_INVERT_OUT,
   input wire [1:0] SECOND_SAMPLE_OUT
);
   reg first_ext;
   // last polarity of the first conversion, the base for the second
   always @(posedge CLOCK_IN or negedge RSTN_IN)
      if (!RSTN_IN)
         first_ext <= 1'b0;
      else if (BUSY_OUT[0] && !SECOND_SAMPLE_OUT[0])
         first_ext <= EXT_PRECHARGE_SUPPLY_OUT[0];
   default clocking @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RSTN_IN);
   a_neg_ref_ground: assert property (NEG_REF_GROUND_OUT)
      else $error("negative reference not ground");
   a_bvalid_stands: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
      else $error("write response dropped early");
   a_rvalid_stands: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN
      |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped early");
   a_read_answer: assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
      else $error("read answer late");
   a_clock_idle: assert property ((BUSY_OUT == 2'b00)[*4] |-> $stable(CONV_CLK_OUT))
      else $error("conversion clock runs while idle");
   a_invert_second: assert property (GUARD_INVERT_OUT[0] |-> SECOND_SAMPLE_OUT[0])
      else $error("inversion outside second conversion");
   a_ext_inverted: assert property (SECOND_SAMPLE_OUT[0] && $past(SECOND_SAMPLE_OUT[0])
      |-> EXT_PRECHARGE_SUPPLY_OUT[0] == (first_ext ^ GUARD_INVERT_OUT[0]))
      else $error("second conversion polarity wrong");
   a_second_busy: assert property ($rose(SECOND_SAMPLE_OUT[1])
      |-> BUSY_OUT[1] && $past(BUSY_OUT[1]))
      else $error("second conversion not back to back");
endmodule

// ==== testbench/cvd_hold_model.sv ====
`timescale 1ns/1ps
module cvd_hold_model
(
   input wire clk_in,
   input wire clear_in,
   input wire conv_clk_in,
   input wire busy_in,
   input wire second_in,
   input wire ext_in,
   output reg [11:0] toggles_out,
   output reg [11:0] busy_cycles_out,
   output reg ext_first_out,
   output reg ext_second_out
);
   reg last_clk;
   // clear re-takes the clock level so an idle high level is not a toggle
   always @(posedge clk_in)
      if (clear_in)
      begin
         last_clk <= conv_clk_in;
         toggles_out <= 12'h000;
         busy_cycles_out <= 12'h000;
         ext_first_out <= 1'b0;
         ext_second_out <= 1'b0;
      end
      else
      begin
         last_clk <= conv_clk_in;
         toggles_out <= toggles_out + (busy_in && (conv_clk_in != last_clk));
         busy_cycles_out <= busy_cycles_out + busy_in;
         if (busy_in && !second_in)
            ext_first_out <= ext_in;
         if (second_in)
            ext_second_out <= ext_in;
      end
endmodule

// ==== testbench/tb_adc_cvd_sequence_control.sv ====
`timescale 1ns/1ps
`include "cvd_ctrl_map.vh"
module tb_adc_cvd_sequence_control;
   reg CLOCK_IN = 0, RSTN_IN = 0, FRC_CLK_IN = 0, clr = 0;
   reg S_AXI_AWVALID_IN = 0, S_AXI_WVALID_IN = 0, S_AXI_BREADY_IN = 0;
   reg S_AXI_ARVALID_IN = 0, S_AXI_RREADY_IN = 0;
   reg [31:0] S_AXI_AWADDR_IN = 0, S_AXI_WDATA_IN = 0, S_AXI_ARADDR_IN = 0;
   reg [3:0] S_AXI_WSTRB_IN = 4'hf;
   wire S_AXI_AWREADY_OUT, S_AXI_WREADY_OUT, S_AXI_BVALID_OUT, S_AXI_ARREADY_OUT;
   wire S_AXI_RVALID_OUT, POS_REF_SUPPLY_OUT, NEG_REF_GROUND_OUT, CONV_CLK_OUT, IRQ_OUT;
   wire [1:0] S_AXI_BRESP_OUT, S_AXI_RRESP_OUT, BUSY_OUT, PRECHARGE_OUT;
   wire [1:0] EXT_PRECHARGE_SUPPLY_OUT, INT_PRECHARGE_POS_OUT, GUARD_INVERT_OUT;
   wire [1:0] SECOND_SAMPLE_OUT;
   wire [31:0] S_AXI_RDATA_OUT;
   wire [5:0] HOLD_A_CHANNEL_OUT, HOLD_B_CHANNEL_OUT;
   wire [11:0] tog, bcyc;
   wire e1, e2;
   integer bad_count = 0, comparisons = 0, cyc = 0, i;
   reg [1:0] r;
   reg [31:0] d;
   reg [10:0] rows [0:7];
   reg [2:0] sel;
   reg [7:0] cv;
   localparam integer ACQ = 16;
   cvd_sequence_control dut (.*);
   cvd_hold_model sh (.clk_in(CLOCK_IN), .clear_in(clr), .conv_clk_in(CONV_CLK_OUT),
      .busy_in(BUSY_OUT[0]), .second_in(SECOND_SAMPLE_OUT[0]),
      .ext_in(EXT_PRECHARGE_SUPPLY_OUT[0]), .toggles_out(tog), .busy_cycles_out(bcyc),
      .ext_first_out(e1), .ext_second_out(e2));
   always #4 CLOCK_IN = ~CLOCK_IN;
   // rc source, deliberately unrelated to the system clock
   always #21 FRC_CLK_IN = ~FRC_CLK_IN;
   always @(posedge CLOCK_IN)
   begin
      cyc = cyc + 1;
      if (cyc == 60000)
      begin
         bad_count = bad_count + 1;
         print_verdict;
      end
   end
   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, bad_count);
         if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input [31:0] s, input [31:0] e, input string n);
      begin
         comparisons = comparisons + 1;
         if (s !== e)
         begin
            bad_count = bad_count + 1;
            $display("FAIL %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   task wr(input [31:0] a, input [31:0] v);
      reg ad, wd;
      begin
         ad = 0;
         wd = 0;
         S_AXI_AWADDR_IN <= a;
         S_AXI_WDATA_IN <= v;
         S_AXI_AWVALID_IN <= 1;
         S_AXI_WVALID_IN <= 1;
         S_AXI_BREADY_IN <= 1;
         while (!(ad && wd))
         begin
            @(posedge CLOCK_IN);
            ad = ad | (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT);
            wd = wd | (S_AXI_WVALID_IN & S_AXI_WREADY_OUT);
            if (ad)
               S_AXI_AWVALID_IN <= 0;
            if (wd)
               S_AXI_WVALID_IN <= 0;
         end
         while (!S_AXI_BVALID_OUT) @(posedge CLOCK_IN);
         r = S_AXI_BRESP_OUT;
         S_AXI_BREADY_IN <= 0;
         @(posedge CLOCK_IN);
      end
   endtask
   task rd(input [31:0] a);
      begin
         S_AXI_ARADDR_IN <= a;
         S_AXI_ARVALID_IN <= 1;
         S_AXI_RREADY_IN <= 1;
         do @(posedge CLOCK_IN); while (!S_AXI_ARREADY_OUT);
         S_AXI_ARVALID_IN <= 0;
         do @(posedge CLOCK_IN); while (!S_AXI_RVALID_OUT);
         d = S_AXI_RDATA_OUT;
         r = S_AXI_RRESP_OUT;
         S_AXI_RREADY_IN <= 0;
         @(posedge CLOCK_IN);
      end
   endtask
   initial
   begin
      rows[0] = 11'h080;
      rows[1] = 11'h141;
      rows[2] = 11'h2c3;
      rows[3] = 11'h302;
      rows[4] = 11'h483;
      rows[5] = 11'h501;
      rows[6] = 11'h743;
      rows[7] = 11'h641;
      repeat (5) @(posedge CLOCK_IN);
      RSTN_IN <= 1;
      @(posedge CLOCK_IN);
      rd(`OFS_CVD3_A);
      chk(d, `CVD3_RESET, "cvd3 reset");
      chk(r, `RESP_OKAY, "read resp");
      wr(`OFS_CVD3_A, 32'h0000_00ff);
      rd(`OFS_CVD3_A);
      chk(d, `CVD3_MASK, "cvd3 bits");
      wr(32'h0000_0040, 32'h0000_0001);
      chk(r, `RESP_SLVERR, "unmapped");
      rd(32'h0000_0040);
      chk(r, `RESP_SLVERR, "unmapped read");
      wr(`OFS_CONV0_A, 32'h0000_0014);
      wr(`OFS_CONV0_B, 32'h0000_0008);
      chk(HOLD_A_CHANNEL_OUT, 5, "hold a");
      chk(HOLD_B_CHANNEL_OUT, 2, "hold b");
      wr(`OFS_MASK, 32'h0000_0001);
      repeat (ACQ) @(posedge CLOCK_IN);
      for (i = 0; i < 8; i = i + 1)
      begin
         sel = rows[i][10:8];
         cv = rows[i][7:0];
         wr(`OFS_CONV1, {25'h0, sel, 3'h0, i[0]});
         wr(`OFS_CVD3_A, cv);
         chk(POS_REF_SUPPLY_OUT, i[0], "pos ref");
         chk(EXT_PRECHARGE_SUPPLY_OUT[0], cv[7], "ext pol");
         chk(INT_PRECHARGE_POS_OUT[0], cv[6], "int pol");
         clr <= 1;
         @(posedge CLOCK_IN);
         clr <= 0;
         wr(`OFS_START, 32'h0000_0001);
         while (!BUSY_OUT[0]) @(posedge CLOCK_IN);
         chk(PRECHARGE_OUT[0], 1, "precharge");
         while (BUSY_OUT[0]) @(posedge CLOCK_IN);
         repeat (3) @(posedge CLOCK_IN);
         chk(tog, 23 * (1 + cv[0]), "toggles");
         if (sel != 7)
            chk(bcyc, 23 * (1 + cv[0]) * (1 << (sel == 6 ? 5 : sel)), "busy cycles");
         chk(e1, cv[7], "first ext");
         if (cv[0])
            chk(e2, cv[7] ^ cv[1], "second ext");
         rd(`OFS_STATUS);
         chk(d, cv[0] ? 5 : 1, "status");
         chk(IRQ_OUT, 1, "irq set");
         wr(`OFS_STATUS, 32'h0000_000f);
         repeat (2) @(posedge CLOCK_IN);
         chk(IRQ_OUT, 0, "irq clear");
      end
      wr(`OFS_MASK, 32'h0000_0000);
      wr(`OFS_CVD3_B, 32'h0000_0083);
      chk(EXT_PRECHARGE_SUPPLY_OUT[1], 1, "ext pol b");
      wr(`OFS_START, 32'h0000_0003);
      while (BUSY_OUT == 2'b00) @(posedge CLOCK_IN);
      while (BUSY_OUT != 2'b00) @(posedge CLOCK_IN);
      repeat (3) @(posedge CLOCK_IN);
      rd(`OFS_STATUS);
      chk(d, 15, "both done");
      chk(IRQ_OUT, 0, "irq masked");
      wr(`OFS_MASK, 32'h0000_0002);
      repeat (2) @(posedge CLOCK_IN);
      chk(IRQ_OUT, 1, "irq b");
      wr(`OFS_START, 32'h0000_0001);
      RSTN_IN <= 0;
      @(posedge CLOCK_IN);
      RSTN_IN <= 1;
      @(posedge CLOCK_IN);
      chk(BUSY_OUT, 0, "busy after reset");
      chk(IRQ_OUT, 0, "irq after reset");
      rd(`OFS_CVD3_A);
      chk(d, `CVD3_RESET, "cvd3 after reset");
      print_verdict;
   end
endmodule
bind cvd_sequence_control cvd_ctrl_checker chk_i (.*);
